// >>> qsram_host_pkg.sv
// Constants and carrier types for the host-side glue that drives a
// byte-wide self-refreshing RAM through its strobe pins.
// Assumes a 250 MHz core clock and a RAM that is clocked only by its
// address capture edge.
//
// Notes on behaviour
// - Host treats busy as wait and stretches the cycle until busy releases.
// - Host suppresses the capture edge during CPU refresh inside opcode fetch.
// - Host raises capture edge at fetch start by setting a flip-flop.
// - Host delays data strobe until after the capture edge has risen.
// - Host keeps write-enable inactive during fetch, interrupt acknowledge or read.
// - Host stops repeated capture edges on every clock during interrupt acknowledge.
// - Strobe bus: address strobe to capture, status to write-enable, strobe direct.

package qsram_host_pkg;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int DS_DELAY_NS    = 12;   // Strobe lag after capture edge
    localparam int DS_DELAY_CYC   = (DS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYNC_STAGES    = 3;
    localparam int REFRESH_ROWS   = 128;
    localparam int BUSY_COUNT     = 17;

    // --------------------------------------------------------------
    // Bus mode selection
    // --------------------------------------------------------------
    localparam logic MODE_FETCH_BUS  = 1'h0;  // Separate request/fetch lines
    localparam logic MODE_STROBE_BUS = 1'h1;  // Multiplexed strobe bus

    // CPU side control lines, all active high here
    typedef struct packed {
        logic opcode_fetch_cycle;
        logic memory_request;
        logic io_request;
        logic read;
        logic write;
        logic host_address_strobe;
        logic host_data_strobe;
        logic host_read_not_write;
    } cpu_ctl_t;

    // RAM pin levels (true pin polarity)
    typedef struct packed {
        logic address_capture_edge;   // Active high clock
        logic data_strobe_n;
        logic write_enable_n;
        logic chip_select_n;
    } ram_ctl_t;

endpackage

// >>> qsram_sync.sv
// Three-stage synchroniser for one asynchronous pin.
// Assumes a single core clock; the output changes once stages two and
// three agree.
`timescale 1ns/1ps

module qsram_sync
    import qsram_host_pkg::*;
#(
    parameter logic RESET_VAL = 1'h0
) (
    input  wire logic i_core_clk,  // Core clock
    input  wire logic i_srst,      // Synchronous reset
    input  wire logic i_pin,       // Raw asynchronous level
    output logic      o_level      // Filtered level
);

    logic [SYNC_STAGES-1:0] stage;

    // --------------------------------------------------------------
    // Shift chain; first stage feeds only the second
    // --------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            stage <= {SYNC_STAGES{RESET_VAL}};
        end else begin
            stage <= {stage[SYNC_STAGES-2:0], i_pin};
        end
    end

    // Accept a change only when two later stages agree
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_level <= RESET_VAL;
        end else if (stage[1] == stage[2]) begin
            o_level <= stage[2];
        end
    end

endmodule

// >>> qsram_host_glue.sv
// Host-side glue that turns CPU bus control lines into the RAM's
// capture edge, data strobe and write-enable, and turns RAM busy into
// a CPU wait request.
// Assumes CPU control lines are synchronous to i_core_clk; busy comes
// from an open-drain pin and is synchronised here.
`timescale 1ns/1ps

module qsram_host_glue
    import qsram_host_pkg::*;
#(
    parameter int DS_LAG = DS_DELAY_CYC   // Strobe falls this many cycles plus one after the capture edge
) (
    input  wire logic     i_core_clk,     // Core clock, 250 MHz
    input  wire logic     i_srst,         // Synchronous reset, active high
    input  wire logic     i_bus_mode,     // Fetch-style or strobe-style bus
    input  wire cpu_ctl_t i_cpu,          // CPU control lines, active high
    input  wire logic     i_cpu_clk_en,   // One-cycle pulse per CPU clock rise
    input  wire logic     i_sel,          // Address decode hit for this RAM
    input  wire logic     i_ram_busy_n,   // RAM busy pin, low means busy
    output ram_ctl_t      o_ram,          // RAM control pins
    output logic          o_cpu_wait      // Wait request to the CPU
);

    // Refuse strobe lags that the 4-bit age counter cannot reach
    if (DS_LAG < 1 || DS_LAG > 15) begin : g_lag_check
        $error("DS_LAG out of range");
    end

    // --------------------------------------------------------------
    // Busy input conditioning
    // --------------------------------------------------------------
    logic busy_n_s;

    qsram_sync #(
        .RESET_VAL (1'h1)
    ) u_busy_sync (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_pin      (i_ram_busy_n),
        .o_level    (busy_n_s)
    );

    // Busy is a wait request for as long as the RAM holds it low
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_cpu_wait <= 1'h0;
        end else begin
            o_cpu_wait <= ~busy_n_s;
        end
    end

    // --------------------------------------------------------------
    // Capture-edge flip-flop
    // --------------------------------------------------------------
    // Set at a fetch start, held through the whole fetch so the CPU's
    // own refresh request and interrupt-acknowledge clocks cannot
    // produce extra capture edges.
    logic fetch_hold;
    logic prev_fetch;
    logic ac_memory_request;
    logic next_ac;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            prev_fetch <= 1'h0;
        end else if (i_cpu_clk_en) begin
            prev_fetch <= i_cpu.opcode_fetch_cycle;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            fetch_hold <= 1'h0;
        end else if (i_cpu_clk_en) begin
            fetch_hold <= i_cpu.opcode_fetch_cycle;
        end
    end

    // Plain memory cycles clock the RAM from the request line
    assign ac_memory_request = i_cpu.memory_request & ~i_cpu.opcode_fetch_cycle
                   & ~i_cpu.io_request;

    always_comb begin
        if (i_bus_mode == MODE_STROBE_BUS) begin
            next_ac = i_cpu.host_address_strobe;
        end else if (i_cpu.opcode_fetch_cycle) begin
            // Raised at fetch start from the gated fetch and CPU clock;
            // refresh request later in the fetch is blocked here
            next_ac = fetch_hold | (i_cpu_clk_en & ~prev_fetch
                      & ~i_cpu.io_request) ? 1'h1 : o_ram.address_capture_edge;
            if (i_cpu.io_request) begin
                next_ac = o_ram.address_capture_edge;
            end
        end else begin
            next_ac = ac_memory_request;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_ram.address_capture_edge <= 1'h0;
        end else begin
            o_ram.address_capture_edge <= next_ac;
        end
    end

    // --------------------------------------------------------------
    // Data strobe delay line
    // --------------------------------------------------------------
    // On the fetch-style bus the strobe may only fall after the capture edge
    // has been high for DS_LAG cycles; the strobe bus passes the CPU strobe straight through.
    logic [3:0] ac_age;
    logic       ds_req;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ac_age <= 4'h0;
        end else if (!o_ram.address_capture_edge) begin
            ac_age <= 4'h0;
        end else if (ac_age != 4'(DS_LAG)) begin
            ac_age <= ac_age + 4'h1;
        end
    end

    assign ds_req = (i_bus_mode == MODE_STROBE_BUS) ? i_cpu.host_data_strobe
                  : (i_cpu.read | i_cpu.write) & i_cpu.memory_request;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_ram.data_strobe_n <= 1'h1;
        end else if (i_bus_mode == MODE_STROBE_BUS) begin
            o_ram.data_strobe_n <= ~ds_req;
        end else begin
            o_ram.data_strobe_n <= ~(ds_req && ac_age == 4'(DS_LAG));
        end
    end

    // --------------------------------------------------------------
    // Write-enable and select
    // --------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_ram.write_enable_n <= 1'h1;
        end else if (i_bus_mode == MODE_STROBE_BUS) begin
            o_ram.write_enable_n <= i_cpu.host_read_not_write;
        end else begin
            o_ram.write_enable_n <= i_cpu.opcode_fetch_cycle | i_cpu.read
                                  | ~i_cpu.write;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_ram.chip_select_n <= 1'h1;
        end else begin
            o_ram.chip_select_n <= ~i_sel;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    a_wait_follows_busy: assert property (@(posedge i_core_clk) disable iff (i_srst)
        $fell(busy_n_s) |=> o_cpu_wait)
        else $error("wait not raised after busy");

    a_ds_after_ac: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_bus_mode == MODE_FETCH_BUS && $fell(o_ram.data_strobe_n))
        |-> $past(o_ram.address_capture_edge))
        else $error("strobe fell before capture edge");

    a_we_held_fetch: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_bus_mode == MODE_FETCH_BUS && (i_cpu.opcode_fetch_cycle || i_cpu.read))
        |=> o_ram.write_enable_n)
        else $error("write-enable active in fetch or read");

    a_iack_no_edge: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_bus_mode == MODE_FETCH_BUS && i_cpu.opcode_fetch_cycle && i_cpu.io_request
         && $past(i_cpu.io_request)) |=> !$rose(o_ram.address_capture_edge))
        else $error("capture edge during interrupt acknowledge");

    a_strobe_map: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_bus_mode == MODE_STROBE_BUS && $past(i_bus_mode) == MODE_STROBE_BUS)
        |-> o_ram.address_capture_edge == $past(i_cpu.host_address_strobe))
        else $error("capture edge not following address strobe");

    a_fetch_raise: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_bus_mode == MODE_FETCH_BUS && i_cpu.opcode_fetch_cycle && fetch_hold
         && !i_cpu.io_request) |=> o_ram.address_capture_edge)
        else $error("capture edge low during fetch");

endmodule

// >>> qsram_ram_model.sv
// Behavioural model of the RAM's refresh and busy logic at its pins.
// Assumes pins are registered on i_core_clk; busy is pulled up.
`timescale 1ns/1ps

module qsram_ram_model
    import qsram_host_pkg::*;
(
    input  wire logic       i_core_clk,  // Core clock
    input  wire logic       i_srst,      // Synchronous reset
    input  wire ram_ctl_t   i_ram,       // RAM control pins
    input  wire logic       i_blk,       // Block select bit
    input  wire logic [3:0] i_hold,      // Busy is held this many cycles plus one
    output logic            o_busy_n,    // Open-drain busy
    output int              o_reads,     // Reads that enabled the outputs
    output int              o_writes     // Writes that stored data
);
    logic       cap_q;
    logic       busy;
    logic [1:0] seen;
    logic [3:0] hold_cnt;
    logic [4:0] cyc_cnt;
    logic [6:0] row;                    // 128 rows

    // Released pin shows the pull-up level, never the last driven value
    assign o_busy_n = busy ? 1'h0 : 1'h1;

    // --------------------------------------------------------------
    // Refresh row and cycle counting
    // --------------------------------------------------------------
    always @(posedge i_core_clk) begin
        cap_q <= i_ram.address_capture_edge;
        if (i_srst) begin
            busy    <= 1'h0;
            seen    <= 2'h0;
            cyc_cnt <= 5'h00;
            row     <= 7'h00;
        end else if (busy) begin
            // Busy releases and the row advances once the hold has run out
            if (hold_cnt == 4'h0) begin
                busy    <= 1'h0;
                row     <= row + 7'h01;
                cyc_cnt <= 5'h00;
                seen    <= 2'h0;
            end else begin
                hold_cnt <= hold_cnt - 4'h1;
            end
        end else if (i_ram.address_capture_edge && !cap_q) begin
            if (i_ram.chip_select_n || (seen | (2'h1 << i_blk)) == 2'h3) begin
                row     <= row + 7'h01;
                cyc_cnt <= 5'h00;
                seen    <= 2'h0;
            end else begin
                seen    <= seen | (2'h1 << i_blk);
                cyc_cnt <= cyc_cnt + 5'h01;
                if (cyc_cnt + 5'h01 == 5'(BUSY_COUNT)) begin
                    busy     <= 1'h1;
                    hold_cnt <= i_hold;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Cycle kind and strobe accounting
    // --------------------------------------------------------------
    logic ds_q;
    logic cyc_on;
    logic cyc_wr;

    // Kind is fixed at the capture edge; a cycle with no strobe leaves data alone
    always @(posedge i_core_clk) begin
        ds_q <= i_ram.data_strobe_n;
        if (i_srst) begin
            cyc_on   <= 1'h0;
            cyc_wr   <= 1'h0;
            o_reads  <= 0;
            o_writes <= 0;
        end else if (i_ram.address_capture_edge && !cap_q && !busy) begin
            cyc_on <= !i_ram.chip_select_n;
            cyc_wr <= !i_ram.write_enable_n;
        end else if (!i_ram.data_strobe_n && ds_q && cyc_on) begin
            if (cyc_wr && !i_ram.write_enable_n) begin
                o_writes <= o_writes + 1;
            end else if (!cyc_wr) begin
                o_reads <= o_reads + 1;
            end
        end
    end
endmodule

// >>> qsram_host_glue_bench.sv
// Self-checking bench for the host glue, closed by the RAM model.
// Assumes registered pins and a synchronised busy input.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

module qsram_host_glue_bench;
    import qsram_host_pkg::*;
    logic       clk, srst, mode, clk_en, sel, busy_n, blk, wt;
    logic [3:0] hold, ev, last, now_v, exp_v;
    cpu_ctl_t   cpu;
    ram_ctl_t   ram;
    int         n_fail, compares, cycles, k, rd_cnt, wr_cnt;
    logic [3:0] expq[$];

    qsram_host_glue u_qsram_host_glue (.i_core_clk(clk), .i_srst(srst), .i_bus_mode(mode), .i_cpu(cpu),
        .i_cpu_clk_en(clk_en), .i_sel(sel), .i_ram_busy_n(busy_n), .o_ram(ram), .o_cpu_wait(wt));
    qsram_ram_model u_qsram_ram_model (.i_core_clk(clk), .i_srst(srst), .i_ram(ram), .i_blk(blk),
        .i_hold(hold), .o_busy_n(busy_n), .o_reads(rd_cnt), .o_writes(wr_cnt));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        clk_en <= 1'($urandom_range(1, 0));
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end

    // Bits: capture edge, strobe_n, write-enable_n, wait
    task automatic note(input int b, input logic v);
        ev[b] = v;
        expq.push_back(ev);
    endtask

    task automatic pulse();
        note(3, 1'h1);
        note(3, 1'h0);
        @(posedge clk) cpu.host_address_strobe <= 1'h1;
        @(posedge clk) cpu.host_address_strobe <= 1'h0;
    endtask

    task automatic results();
        $display("mismatches %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watcher: every pin change consumes the oldest expected value
    always @(negedge clk) begin
        now_v = {ram.address_capture_edge, ram.data_strobe_n, ram.write_enable_n, wt};
        if (!srst && now_v !== last) begin
            if (expq.size() == 0) `CHK("spurious pins", last, now_v)
            else begin
                exp_v = expq.pop_front();
                `CHK("pins", exp_v, now_v)
            end
        end
        last = now_v;
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        void'($urandom(32'h4f6b6e4e));
        srst = 1'h1; mode = MODE_STROBE_BUS; cpu = '0; cpu.host_read_not_write = 1'h1;
        clk_en = 1'h0; sel = 1'h1; blk = 1'h0; hold = 4'h5; ev = 4'h6;
        repeat (20) @(posedge clk);
        `CHK("reset pins", 4'h6, now_v)
        `CHK("reset select", 1'h1, ram.chip_select_n)
        srst <= 1'h0;
        // Strobe bus: reads and writes with a random strobe lag
        for (int i = 0; i < 4; i++) begin
            k = $urandom_range(4, 1);
            blk <= i[0];
            @(posedge clk) cpu.host_read_not_write <= ~i[1];
            if (i[1]) note(1, 1'h0);
            pulse();
            repeat (k) @(posedge clk);
            cpu.host_data_strobe <= 1'h1;
            note(2, 1'h0);
            @(posedge clk) cpu.host_data_strobe <= 1'h0;
            cpu.host_read_not_write <= 1'h1;
            ev[1] = 1'h1;
            note(2, 1'h1);
        end
        // Alternating blocks and random deselects never raise wait
        for (int i = 0; i < 20; i++) begin
            blk <= i[0];
            sel <= 1'($urandom_range(1, 0));
            pulse();
        end
        sel <= 1'h0;
        hold <= 4'($urandom_range(10, 3));
        repeat (2) @(posedge clk);
        pulse();
        sel <= 1'h1;
        blk <= 1'h1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 16; i++) pulse();
        repeat (10) @(posedge clk);
        pulse();
        note(0, 1'h1);
        // Host issues nothing while the wait request stands
        for (k = 0; k < 20 && wt !== 1'h1; k++) @(posedge clk);
        `CHK("wait raised", 1'h1, wt)
        note(0, 1'h0);
        for (k = 0; k < 40 && wt !== 1'h0; k++) @(posedge clk);
        `CHK("wait released", 1'h0, wt)
        // Fetch-style bus: plain read, then an I/O cycle
        mode <= MODE_FETCH_BUS;
        repeat (3) @(posedge clk);
        cpu.memory_request <= 1'h1;
        cpu.read <= 1'h1;
        note(3, 1'h1);
        note(2, 1'h0);
        repeat (8) @(posedge clk);
        cpu.memory_request <= 1'h0;
        cpu.read <= 1'h0;
        ev[3] = 1'h0;
        note(2, 1'h1);
        repeat (2) @(posedge clk);
        cpu.io_request <= 1'h1;
        repeat (6) @(posedge clk);
        cpu.io_request <= 1'h0;
        repeat (10) @(posedge clk);
        // Opcode fetch: edge from the CPU clock, later refresh request blocked
        cpu.opcode_fetch_cycle <= 1'h1;
        cpu.memory_request <= 1'h1;
        cpu.read <= 1'h1;
        note(3, 1'h1);
        note(2, 1'h0);
        for (k = 0; k < 40 && ram.address_capture_edge !== 1'h1; k++) @(posedge clk);
        `CHK("fetch edge", 1'h1, ram.address_capture_edge)
        repeat (8) @(posedge clk);
        cpu.memory_request <= 1'h0;
        cpu.read <= 1'h0;
        note(2, 1'h1);
        repeat (2) @(posedge clk);
        cpu.memory_request <= 1'h1;
        repeat (4) @(posedge clk);
        cpu.opcode_fetch_cycle <= 1'h0;
        cpu.memory_request <= 1'h0;
        note(3, 1'h0);
        repeat (4) @(posedge clk);
        // Interrupt acknowledge: one edge, no strobe, seen as an aborted read
        cpu.opcode_fetch_cycle <= 1'h1;
        note(3, 1'h1);
        for (k = 0; k < 40 && ram.address_capture_edge !== 1'h1; k++) @(posedge clk);
        `CHK("iack edge", 1'h1, ram.address_capture_edge)
        cpu.io_request <= 1'h1;
        repeat (12) @(posedge clk);
        cpu.opcode_fetch_cycle <= 1'h0;
        cpu.io_request <= 1'h0;
        note(3, 1'h0);
        repeat (6) @(posedge clk);
        `CHK("reads", 4, rd_cnt)
        `CHK("writes", 2, wr_cnt)
        `CHK("pending notes", 0, expq.size())
        results();
    end
endmodule
